// ### common/pfc_pkg.sv
// shared constants and types for the dual-slope pwm timer
package pfc_pkg;

    // register indices on the plain register port
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_COUNT = 3'h1;
    localparam logic [2:0] REG_CMP_A = 3'h2;
    localparam logic [2:0] REG_CMP_B = 3'h3;
    localparam logic [2:0] REG_CAPTURE = 3'h4;
    localparam logic [2:0] REG_INT_STATUS = 3'h5;
    localparam logic [2:0] REG_INT_MASK = 3'h6;

    // control register field positions
    localparam int CTRL_WGM_LSB = 0;
    localparam int CTRL_COM_A_LSB = 4;
    localparam int CTRL_COM_B_LSB = 6;
    localparam int CTRL_CS_LSB = 8;
    localparam int CTRL_DDR_LSB = 11;

    // interrupt status / mask bit positions
    localparam int ST_OVF = 0;
    localparam int ST_CMP_A = 1;
    localparam int ST_CMP_B = 2;
    localparam int ST_CAP = 3;

    // waveform mode select codes handled here
    localparam logic [3:0] WGM_PFC_CAPTURE_TOP = 4'h8;
    localparam logic [3:0] WGM_PFC_CMP_A_TOP = 4'h9;

    // compare output mode codes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NON_INV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;

    // clock select codes and prescaler tap masks
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] PRE_MASK_DIV1 = 10'h000;
    localparam logic [9:0] PRE_MASK_DIV8 = 10'h007;
    localparam logic [9:0] PRE_MASK_DIV64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_DIV256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_DIV1024 = 10'h3ff;

    // reset values and count limits
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] TOP_MIN = 16'h0003;

    typedef enum logic [0:0] {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } pfc_dir_t;

    // whole state of the timer
    typedef struct packed {
        logic [9:0] pre;
        logic [15:0] count;
        pfc_dir_t dir;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] act_a;
        logic [15:0] act_b;
        logic [15:0] capture;
        logic [3:0] wgm;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] cs;
        logic [1:0] ddr;
        logic [1:0] oc;
        logic [3:0] status;
        logic [3:0] mask;
        logic [15:0] rdata;
    } pfc_state_t;

endpackage

// ### rtl/pfc_pwm.sv
// phase and frequency correct pwm timer with two compare channels
`timescale 1ns/10ps
`default_nettype none

// How it works
// RL1 - modes 0x8 and 0x9 run this timer
// RL2 - count climbs zero to top, then descends
// RL3 - non-inverting clears up-match, sets down-match
// RL4 - mode 0x2 non-inverted, 0x3 inverted
// RL5 - top from capture or channel-a compare
// RL6 - count stays at top one tick
// RL7 - compare flag set on each match
// RL8 - overflow flag with buffer load at bottom
// RL9 - top sets channel-a or capture flag
// RL10 - software keeps top above compare values
// RL11 - top at least three, up to 16-bit
// RL12 - zero compare low, top compare high; opposite levels when inverted
// RL13 - channel-a toggle gives square wave in mode 0x9 only
// RL14 - pin driven only when direction bit set
// RL15 - tick from prescaler, five divide choices
// RL16 - tick is enable, single clock only
// RL17 - software prefers channel-a top for retuning
// RL18 - sticky flags, masked level interrupt request
module pfc_pwm (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // compare output pins
    output logic [1:0] pwm_out,
    output logic [1:0] pwm_oe,
    // interrupt
    output logic irq
);

    pfc_pkg::pfc_state_t s_q;
    pfc_pkg::pfc_state_t s_d;

    logic pfc_mode;
    logic [15:0] top;
    logic [9:0] pre_mask;
    logic tick;
    logic at_top;
    logic at_bottom;
    logic counting_up;
    logic wr_ctrl;
    logic wr_count;
    logic [1:0] match;
    logic [1:0] pin_en;
    logic [15:0] act [2];
    logic [1:0] com [2];

    assign wr_ctrl = reg_wr && (reg_addr == pfc_pkg::REG_CTRL);
    assign wr_count = reg_wr && (reg_addr == pfc_pkg::REG_COUNT);

    assign pfc_mode = (s_q.wgm == pfc_pkg::WGM_PFC_CAPTURE_TOP)
                   || (s_q.wgm == pfc_pkg::WGM_PFC_CMP_A_TOP); // see RL1

    // double-buffered channel-a top follows period edges, safe to retune
    assign top = (s_q.wgm == pfc_pkg::WGM_PFC_CMP_A_TOP) ? s_q.act_a
                                                         : s_q.capture; // see RL5 see RL17

    // top below three is not guarded; resolution simply drops
    assign at_top = (s_q.count == top); // see RL11
    assign at_bottom = (s_q.count == pfc_pkg::BOTTOM);

    // bottom counts as rising edge, top as falling: gives the extreme levels
    always_comb begin
        if (at_bottom) begin
            counting_up = 1'b1;
        end else if (at_top) begin
            counting_up = 1'b0;
        end else begin
            counting_up = (s_q.dir == pfc_pkg::DIR_UP);
        end
    end // see RL12

    always_comb begin
        case (s_q.cs)
            pfc_pkg::CS_DIV1: pre_mask = pfc_pkg::PRE_MASK_DIV1;
            pfc_pkg::CS_DIV8: pre_mask = pfc_pkg::PRE_MASK_DIV8;
            pfc_pkg::CS_DIV64: pre_mask = pfc_pkg::PRE_MASK_DIV64;
            pfc_pkg::CS_DIV256: pre_mask = pfc_pkg::PRE_MASK_DIV256;
            default: pre_mask = pfc_pkg::PRE_MASK_DIV1024;
        endcase
    end

    // external-clock codes are treated as stopped here
    assign tick = (s_q.cs != pfc_pkg::CS_STOP) && (s_q.cs <= pfc_pkg::CS_DIV1024)
               && ((s_q.pre & pre_mask) == pre_mask); // see RL15 see RL16

    assign act[0] = s_q.act_a;
    assign act[1] = s_q.act_b;
    assign com[0] = s_q.com_a;
    assign com[1] = s_q.com_b;

    // a compare value above top never matches
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            assign match[ch] = tick && pfc_mode && (s_q.count == act[ch]); // see RL7 see RL10
            // toggle only exists on channel a; b treats it as disconnected
            assign pin_en[ch] = s_q.ddr[ch] && ((com[ch] == pfc_pkg::COM_NON_INV)
                             || (com[ch] == pfc_pkg::COM_INV)
                             || ((ch == 0) && (com[ch] == pfc_pkg::COM_TOGGLE))); // see RL14
        end
    endgenerate

    always_comb begin
        logic [3:0] set_ev;
        logic [3:0] clr;
        logic [15:0] rd;
        set_ev = 4'h0;
        clr = 4'h0;
        rd = 16'h0000;
        s_d = s_q;

        // prescaler runs freely on the i/o clock
        s_d.pre = s_q.pre + 10'h001; // see RL15

        // counter motion, one step per tick
        if (tick && pfc_mode) begin
            if (at_bottom) begin
                s_d.act_a = s_q.buf_a; // see RL8
                s_d.act_b = s_q.buf_b;
                set_ev[pfc_pkg::ST_OVF] = 1'b1; // see RL8
                s_d.dir = pfc_pkg::DIR_UP;
                s_d.count = s_q.count + 16'h0001; // see RL2
            end else if (s_q.dir == pfc_pkg::DIR_UP) begin
                if (at_top) begin
                    s_d.dir = pfc_pkg::DIR_DOWN; // see RL6
                    s_d.count = s_q.count - 16'h0001;
                    if (s_q.wgm == pfc_pkg::WGM_PFC_CMP_A_TOP) begin
                        set_ev[pfc_pkg::ST_CMP_A] = 1'b1; // see RL9
                    end else begin
                        set_ev[pfc_pkg::ST_CAP] = 1'b1; // see RL9
                    end
                end else begin
                    s_d.count = s_q.count + 16'h0001; // see RL2
                end
            end else begin
                s_d.count = s_q.count - 16'h0001; // see RL2
            end
        end

        // compare outputs and flags
        if (match[0]) begin
            set_ev[pfc_pkg::ST_CMP_A] = 1'b1; // see RL7
        end
        if (match[1]) begin
            set_ev[pfc_pkg::ST_CMP_B] = 1'b1; // see RL7
        end
        for (int ch = 0; ch < 2; ch++) begin
            if (match[ch]) begin
                case (com[ch])
                    pfc_pkg::COM_NON_INV: s_d.oc[ch] = !counting_up; // see RL3 see RL4
                    pfc_pkg::COM_INV: s_d.oc[ch] = counting_up; // see RL3 see RL4
                    pfc_pkg::COM_TOGGLE: begin
                        if (ch == 0 && s_q.wgm == pfc_pkg::WGM_PFC_CMP_A_TOP) begin
                            s_d.oc[ch] = !s_q.oc[ch]; // see RL13
                        end
                    end
                    default: s_d.oc[ch] = s_q.oc[ch];
                endcase
            end
        end

        // register writes; a count write overrides the tick step
        if (reg_wr) begin
            case (reg_addr)
                pfc_pkg::REG_CTRL: begin
                    s_d.wgm = reg_wdata[pfc_pkg::CTRL_WGM_LSB +: 4];
                    s_d.com_a = reg_wdata[pfc_pkg::CTRL_COM_A_LSB +: 2];
                    s_d.com_b = reg_wdata[pfc_pkg::CTRL_COM_B_LSB +: 2];
                    s_d.cs = reg_wdata[pfc_pkg::CTRL_CS_LSB +: 3];
                    s_d.ddr = reg_wdata[pfc_pkg::CTRL_DDR_LSB +: 2];
                end
                pfc_pkg::REG_COUNT: s_d.count = reg_wdata;
                pfc_pkg::REG_CMP_A: s_d.buf_a = reg_wdata;
                pfc_pkg::REG_CMP_B: s_d.buf_b = reg_wdata;
                pfc_pkg::REG_CAPTURE: s_d.capture = reg_wdata;
                pfc_pkg::REG_INT_STATUS: clr = reg_wdata[3:0];
                pfc_pkg::REG_INT_MASK: s_d.mask = reg_wdata[3:0];
                default: s_d.mask = s_q.mask;
            endcase
        end

        // set wins over a write-one clear in the same cycle
        s_d.status = (s_q.status & ~clr) | set_ev; // see RL18

        // read data appears the cycle after the strobe
        case (reg_addr)
            pfc_pkg::REG_CTRL: begin
                rd[pfc_pkg::CTRL_WGM_LSB +: 4] = s_q.wgm;
                rd[pfc_pkg::CTRL_COM_A_LSB +: 2] = s_q.com_a;
                rd[pfc_pkg::CTRL_COM_B_LSB +: 2] = s_q.com_b;
                rd[pfc_pkg::CTRL_CS_LSB +: 3] = s_q.cs;
                rd[pfc_pkg::CTRL_DDR_LSB +: 2] = s_q.ddr;
            end
            pfc_pkg::REG_COUNT: rd = s_q.count;
            pfc_pkg::REG_CMP_A: rd = s_q.buf_a;
            pfc_pkg::REG_CMP_B: rd = s_q.buf_b;
            pfc_pkg::REG_CAPTURE: rd = s_q.capture;
            pfc_pkg::REG_INT_STATUS: rd = {12'h000, s_q.status};
            pfc_pkg::REG_INT_MASK: rd = {12'h000, s_q.mask};
            default: rd = 16'h0000;
        endcase
        s_d.rdata = reg_rd ? rd : 16'h0000;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{
                pre: 10'h000,
                count: pfc_pkg::COUNT_RESET,
                dir: pfc_pkg::DIR_UP,
                buf_a: pfc_pkg::CMP_RESET,
                buf_b: pfc_pkg::CMP_RESET,
                act_a: pfc_pkg::CMP_RESET,
                act_b: pfc_pkg::CMP_RESET,
                capture: pfc_pkg::CMP_RESET,
                wgm: 4'h0,
                com_a: pfc_pkg::COM_OFF,
                com_b: pfc_pkg::COM_OFF,
                cs: pfc_pkg::CS_STOP,
                ddr: 2'h0,
                oc: 2'h0,
                status: 4'h0,
                mask: 4'h0,
                rdata: 16'h0000
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign pwm_out = s_q.oc & pin_en; // see RL14
    assign pwm_oe = pin_en;
    assign irq = |(s_q.status & s_q.mask); // see RL18

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_IDLE_OUTSIDE_MODE: assert property ( // see RL1
        !pfc_mode && !wr_count |=> s_q.count == $past(s_q.count)
    ) else $error("count moved outside the dual-slope modes");

    AST_UP_STEP: assert property ( // see RL2
        tick && pfc_mode && !wr_count && s_q.dir == pfc_pkg::DIR_UP && !at_top
        |=> s_q.count == $past(s_q.count) + 16'h0001
    ) else $error("count did not rise by one on an up tick");

    AST_DOWN_STEP: assert property ( // see RL2
        tick && pfc_mode && !wr_count && s_q.dir == pfc_pkg::DIR_DOWN && !at_bottom
        |=> s_q.count == $past(s_q.count) - 16'h0001
    ) else $error("count did not fall by one on a down tick");

    AST_TOP_ONE_TICK: assert property ( // see RL6
        tick && pfc_mode && !wr_count && s_q.dir == pfc_pkg::DIR_UP && at_top
        && !at_bottom
        |=> s_q.dir == pfc_pkg::DIR_DOWN && s_q.count == $past(s_q.count) - 16'h0001
    ) else $error("count did not turn down after one tick at top");

    AST_NON_INV_UP_CLEAR: assert property ( // see RL3
        match[1] && s_q.com_b == pfc_pkg::COM_NON_INV && counting_up
        |=> !s_q.oc[1]
    ) else $error("non-inverted output not cleared on up-count match");

    AST_INV_DOWN_CLEAR: assert property ( // see RL4
        match[1] && s_q.com_b == pfc_pkg::COM_INV && !counting_up
        |=> !s_q.oc[1]
    ) else $error("inverted output not cleared on down-count match");

    AST_NON_INV_DOWN_SET: assert property ( // see RL3
        match[1] && s_q.com_b == pfc_pkg::COM_NON_INV && !counting_up
        |=> s_q.oc[1]
    ) else $error("non-inverted output not set on down-count match");

    AST_INV_UP_SET: assert property ( // see RL4
        match[0] && s_q.com_a == pfc_pkg::COM_INV && counting_up
        |=> s_q.oc[0]
    ) else $error("inverted output not set on up-count match");

    AST_TOP_SOURCE: assert property ( // see RL5
        s_q.wgm == pfc_pkg::WGM_PFC_CAPTURE_TOP |-> top == s_q.capture
    ) else $error("capture value not used as top");

    AST_CMP_B_FLAG: assert property ( // see RL7
        match[1] |=> s_q.status[pfc_pkg::ST_CMP_B]
    ) else $error("channel-b match flag not set");

    AST_OVF_WITH_LOAD: assert property ( // see RL8
        tick && pfc_mode && at_bottom && !reg_wr
        |=> s_q.status[pfc_pkg::ST_OVF] && s_q.act_a == $past(s_q.buf_a)
    ) else $error("overflow flag and buffer load not together at bottom");

    AST_CAPTURE_FLAG_AT_TOP: assert property ( // see RL9
        tick && s_q.wgm == pfc_pkg::WGM_PFC_CAPTURE_TOP && s_q.dir == pfc_pkg::DIR_UP
        && at_top && !at_bottom |=> s_q.status[pfc_pkg::ST_CAP]
    ) else $error("capture flag not set at top");

    AST_CMP_A_FLAG_AT_TOP: assert property ( // see RL9
        tick && s_q.wgm == pfc_pkg::WGM_PFC_CMP_A_TOP && s_q.dir == pfc_pkg::DIR_UP
        && at_top && !at_bottom |=> s_q.status[pfc_pkg::ST_CMP_A]
    ) else $error("channel-a flag not set at top");

    AST_TOGGLE_SQUARE: assert property ( // see RL13
        match[0] && s_q.com_a == pfc_pkg::COM_TOGGLE && s_q.wgm == pfc_pkg::WGM_PFC_CMP_A_TOP
        |=> s_q.oc[0] != $past(s_q.oc[0])
    ) else $error("channel-a output did not toggle on match");

    AST_PIN_DIRECTION: assert property ( // see RL14
        !s_q.ddr[0] |-> !pwm_oe[0] && !pwm_out[0]
    ) else $error("channel-a pin driven with direction bit clear");

    AST_DIV1_TICK: assert property ( // see RL15
        s_q.cs == pfc_pkg::CS_DIV1 |-> tick
    ) else $error("undivided clock select missed a tick");

    // uneven tick spacing would break the symmetry of the two slopes
    AST_DIV8_SPACING: assert property ( // see RL15
        tick && s_q.cs == pfc_pkg::CS_DIV8
        |=> (!tick || s_q.cs != pfc_pkg::CS_DIV8) [*7]
    ) else $error("divide-by-eight tick came early");

    AST_STOPPED_NO_TICK: assert property ( // see RL16
        s_q.cs == pfc_pkg::CS_STOP |-> !tick
    ) else $error("tick seen with the timer stopped");

    AST_IRQ_STICKY: assert property ( // see RL18
        (s_q.status & s_q.mask) != 4'h0
        && !(reg_wr && (reg_addr == pfc_pkg::REG_INT_STATUS
        || reg_addr == pfc_pkg::REG_INT_MASK)) |=> irq
    ) else $error("interrupt dropped while flag and mask stay set");

    AST_FLAG_STICKY: assert property ( // see RL18
        !(reg_wr && reg_addr == pfc_pkg::REG_INT_STATUS)
        |=> (s_q.status & $past(s_q.status)) == $past(s_q.status)
    ) else $error("interrupt flag dropped without a clear");

endmodule

`default_nettype wire

// ### verification/pfc_load_model.sv
// load on the two pwm pins: measures run lengths and edges
`timescale 1ns/10ps
`default_nettype none
module pfc_load_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins from the timer
    input wire logic [1:0] pwm_out,
    input wire logic [1:0] pwm_oe,
    // measured waveform
    output logic [1:0] pin_level,
    output logic [1:0][15:0] high_len_q,
    output logic [1:0][15:0] low_len_q,
    output logic [1:0][15:0] edge_cnt_q
);
    logic [1:0][15:0] run_q;
    logic [1:0] prev_q;

    // pull-down: a pin not driven reads low
    assign pin_level = pwm_out & pwm_oe;

    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!rst_n) begin
                run_q[i] <= 16'h0000;
                prev_q[i] <= 1'b0;
                high_len_q[i] <= 16'h0000;
                low_len_q[i] <= 16'h0000;
                edge_cnt_q[i] <= 16'h0000;
            end else if (pin_level[i] != prev_q[i]) begin
                if (prev_q[i]) begin
                    high_len_q[i] <= run_q[i];
                end else begin
                    low_len_q[i] <= run_q[i];
                end
                run_q[i] <= 16'h0001;
                prev_q[i] <= pin_level[i];
                edge_cnt_q[i] <= edge_cnt_q[i] + 16'h0001;
            end else begin
                run_q[i] <= run_q[i] + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/pfc_pwm_test.sv
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/10ps
`default_nettype none
module pfc_pwm_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] pwm_out;
    logic [1:0] pwm_oe;
    logic irq;
    logic [1:0] lvl;
    logic [1:0][15:0] hi;
    logic [1:0][15:0] lo;
    logic [1:0][15:0] edg;
    logic [15:0] e0;
    int num_errors = 0;
    int total_checks = 0;

    always #4 clk = ~clk;

    pfc_pwm u_pfc_pwm (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .irq(irq));
    pfc_load_model u_pfc_load_model (.clk(clk), .rst_n(rst_n), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .pin_level(lvl), .high_len_q(hi), .low_len_q(lo), .edge_cnt_q(edg));

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // edge after the strobe lets the write land before the next access
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
        @(posedge clk);
    endtask

    function automatic logic [15:0] mk_ctl(logic [3:0] m, logic [1:0] ca, logic [1:0] cb,
            logic [2:0] cs, logic [1:0] ddr);
        return 16'(m) | (16'(ca) << 4) | (16'(cb) << 6) | (16'(cs) << 8) | (16'(ddr) << 11);
    endfunction

    // stop and rewind first so every run starts at bottom
    task automatic setup(input logic [15:0] c, input logic [15:0] ca, input logic [15:0] cb,
            input logic [15:0] cap, input int n);
        wr(pfc_pkg::REG_CTRL, 16'h0000);
        wr(pfc_pkg::REG_COUNT, 16'h0000);
        wr(pfc_pkg::REG_CMP_A, ca);
        wr(pfc_pkg::REG_CMP_B, cb);
        wr(pfc_pkg::REG_CAPTURE, cap);
        wr(pfc_pkg::REG_INT_STATUS, 16'h000f);
        wr(pfc_pkg::REG_CTRL, c);
        repeat (n) @(posedge clk);
    endtask

    task automatic test_reset();
        check("oe rst", 16'h0000, 16'(pwm_oe));
        check("irq rst", 16'h0000, 16'(irq));
        rd_chk("ctrl rst", pfc_pkg::REG_CTRL, 16'h0000);
        rd_chk("mask rst", pfc_pkg::REG_INT_MASK, 16'h0000);
        wr(pfc_pkg::REG_CTRL, mk_ctl(4'h0, 2'h0, 2'h0, pfc_pkg::CS_DIV1, 2'h0));
        wr(pfc_pkg::REG_COUNT, 16'h0005);
        repeat (5) @(posedge clk);
        rd_chk("count frozen", pfc_pkg::REG_COUNT, 16'h0005);
        wr(pfc_pkg::REG_CMP_B, 16'h1234);
        rd_chk("cmp b", pfc_pkg::REG_CMP_B, 16'h1234);
        @(posedge clk);
        check("rdata idle", 16'h0000, reg_rdata);
        wr(3'h7, 16'hffff);
        rd_chk("unmapped", 3'h7, 16'h0000);
    endtask

    task automatic test_mode9();
        setup(mk_ctl(pfc_pkg::WGM_PFC_CMP_A_TOP, pfc_pkg::COM_OFF, pfc_pkg::COM_NON_INV,
            pfc_pkg::CS_DIV1, 2'h3), 16'h0005, 16'h0002, 16'h0000, 40);
        check("oe", 16'h0002, 16'(pwm_oe));
        check("b high", 16'h0004, hi[1]);
        check("b low", 16'h0006, lo[1]);
        check("irq masked", 16'h0000, 16'(irq));
        wr(pfc_pkg::REG_INT_MASK, 16'h0004);
        check("irq", 16'h0001, 16'(irq));
        wr(pfc_pkg::REG_CTRL, 16'h0000);
        rd_chk("flags", pfc_pkg::REG_INT_STATUS, 16'h0007);
        wr(pfc_pkg::REG_INT_STATUS, 16'h0007);
        check("irq clr", 16'h0000, 16'(irq));
        rd_chk("flags clr", pfc_pkg::REG_INT_STATUS, 16'h0000);
        wr(pfc_pkg::REG_INT_MASK, 16'h0000);
    endtask

    task automatic test_mode8();
        setup(mk_ctl(pfc_pkg::WGM_PFC_CAPTURE_TOP, pfc_pkg::COM_INV, pfc_pkg::COM_NON_INV,
            pfc_pkg::CS_DIV8, 2'h3), 16'h0001, 16'h0003, 16'h0004, 200);
        check("a high", 16'h0030, hi[0]);
        check("a low", 16'h0010, lo[0]);
        check("b high", 16'h0030, hi[1]);
        check("b low", 16'h0010, lo[1]);
        wr(pfc_pkg::REG_CTRL, 16'h0000);
        rd_chk("flags", pfc_pkg::REG_INT_STATUS, 16'h000f);
    endtask

    task automatic test_edges();
        setup(mk_ctl(pfc_pkg::WGM_PFC_CMP_A_TOP, pfc_pkg::COM_TOGGLE, pfc_pkg::COM_NON_INV,
            pfc_pkg::CS_DIV1, 2'h3), 16'h0004, 16'h0000, 16'h0000, 40);
        e0 = edg[1];
        check("a high", 16'h0008, hi[0]);
        check("a low", 16'h0008, lo[0]);
        repeat (20) @(posedge clk);
        check("b zero lvl", 16'h0000, 16'(lvl[1]));
        check("b zero edges", e0, edg[1]);
        setup(mk_ctl(pfc_pkg::WGM_PFC_CMP_A_TOP, pfc_pkg::COM_OFF, pfc_pkg::COM_INV,
            pfc_pkg::CS_DIV1, 2'h3), 16'h0004, 16'h0004, 16'h0000, 20);
        e0 = edg[1];
        repeat (20) @(posedge clk);
        check("b top lvl", 16'h0000, 16'(lvl[1]));
        check("b top edges", e0, edg[1]);
        setup(mk_ctl(pfc_pkg::WGM_PFC_CAPTURE_TOP, pfc_pkg::COM_OFF, pfc_pkg::COM_NON_INV,
            pfc_pkg::CS_DIV1, 2'h1), 16'h0003, 16'h0006, 16'h0003, 30);
        check("b oe off", 16'h0000, 16'(pwm_oe));
        wr(pfc_pkg::REG_CTRL, 16'h0000);
        rd_chk("no b match", pfc_pkg::REG_INT_STATUS, 16'h000b);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_reset();
        test_mode9();
        test_mode8();
        test_edges();
        finish_test();
    end
endmodule
`default_nettype wire
